// File: dv/avc_top_chk.sv
// checker of the comparator top: scan timing, contact hold, register ranges
// assumes it is bound to avc_top and sees its ports only
`timescale 1ns/100ps
`include "avc_map.svh"
module avc_top_chk (
    // clock and reset
    input wire logic                   ref_clk_i,
    input wire logic                   rst_b_i,
    // register port
    input wire logic [`AVC_ADDR_W-1:0] reg_addr_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic [`AVC_DATA_W-1:0] reg_rdata_o,
    // scan and contact
    input wire logic                   scan_i,
    input wire logic                   scan_done_o,
    input wire logic                   contact_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_scan_answered: assert property (scan_i |-> ##2 scan_done_o)
        else $error("scan not answered two cycles later");
    a_done_from_scan: assert property (scan_done_o |-> $past(scan_i, 2))
        else $error("scan done without a scan");
    a_contact_holds: assert property ($changed(contact_o) |->
        scan_done_o || $past(reg_wr_i) || $past(reg_wr_i, 2))
        else $error("contact moved without evaluation");
    a_read_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
        else $error("read data outside read cycle");
    a_gain1_range: assert property (reg_rd_i && reg_addr_i == `AVC_REG_GAIN1
        |=> reg_rdata_o <= 32'h0000270F)
        else $error("first gain above range");
    a_gain2_range: assert property (reg_rd_i && reg_addr_i == `AVC_REG_GAIN2
        |=> reg_rdata_o <= 32'h0000270F)
        else $error("second gain above range");
    a_offset_range: assert property (reg_rd_i && reg_addr_i == `AVC_REG_OFFSET
        |=> reg_rdata_o <= 32'h0000270F)
        else $error("offset above range");
    a_hyst_range: assert property (reg_rd_i && reg_addr_i == `AVC_REG_HYST
        |=> reg_rdata_o <= 32'h0000270F)
        else $error("hysteresis above range");
    a_value_no_wrap: assert property (reg_rd_i && (reg_addr_i == `AVC_REG_VAL1
        || reg_addr_i == `AVC_REG_VAL2) |=> !reg_rdata_o[31])
        else $error("operand value wrapped negative");
endmodule : avc_top_chk

bind avc_top avc_top_chk avc_top_chk_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .scan_i(scan_i), .scan_done_o(scan_done_o), .contact_o(contact_o));

// File: dv/tb_avc_top.sv
// self-checking bench of the analog value comparator top
// assumes avc_top and its bound checker are compiled before it
`timescale 1ns/100ps
`include "avc_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %0h expected %0h", $time, (g), (e)); end end
module tb_avc_top;
    import avc_pkg::*;
    logic                             ref_clk_i = 1'b0;
    logic                             rst_b_i = 1'b0;
    logic [`AVC_ADDR_W-1:0]           reg_addr_i = '0;
    logic [`AVC_DATA_W-1:0]           reg_wdata_i = '0;
    logic                             reg_wr_i = 1'b0;
    logic                             reg_rd_i = 1'b0;
    logic [`AVC_DATA_W-1:0]           reg_rdata_o;
    logic [`AVC_ANA_N*`AVC_ANA_W-1:0] analog_pin_i = '0;
    logic [`AVC_TC_N*`AVC_TC_W-1:0]   timer_value_i = '0;
    logic [`AVC_TC_N*`AVC_TC_W-1:0]   counter_value_i = '0;
    logic                             scan_i = 1'b0;
    logic                             scan_done_o;
    logic                             contact_o;
    int                               fails = 0;
    int                               n_tests = 0;
    logic [31:0]                      rv;
    logic                             exp_c;
    logic [9:0]                       seq [10] = '{10'h064, 10'h06E, 10'h082, 10'h05A,
        10'h06E, 10'h07E, 10'h04A, 10'h064, 10'h050, 10'h04A};

    always #2 ref_clk_i = ~ref_clk_i;

    avc_top avc_top_i (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .analog_pin_i(analog_pin_i),
        .timer_value_i(timer_value_i), .counter_value_i(counter_value_i),
        .scan_i(scan_i), .scan_done_o(scan_done_o), .contact_o(contact_o));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask : rd

    // sets analog channel 0, lets the sync settle, scans and waits for done
    task automatic scan(input logic [9:0] a);
        int k;
        @(posedge ref_clk_i);
        analog_pin_i[9:0] <= a;
        repeat (3) @(posedge ref_clk_i);
        scan_i <= 1'b1;
        @(posedge ref_clk_i);
        scan_i <= 1'b0;
        #1;
        for (k = 0; k < 8 && scan_done_o !== 1'b1; k++) begin
            @(posedge ref_clk_i);
            #1;
        end
        if (scan_done_o !== 1'b1) begin
            fails++;
            $display("[ERR] %0t scan never answered", $time);
            end_of_test();
        end
    endtask : scan

    // expected contact from mode, operands, hysteresis and previous state
    function automatic logic next_c(input int m, input int a, input int b, input int h,
                                    input logic c);
        logic on;
        logic off;
        on  = (m == 0) ? a < b : (m == 1) ? a <= b : (m == 2) ? a == b :
              (m == 3) ? a >= b : a > b;
        off = (m < 2) ? a > b + h : (m == 2) ? (a < b - h || a > b + h) : a < b - h;
        return on ? 1'b1 : off ? 1'b0 : c;
    endfunction : next_c

    initial begin
        int m;
        int i;
        repeat (16) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rd(`AVC_REG_CTRL);
        `CHK(rv, 32'h00000000)
        rd(`AVC_REG_HYST);
        `CHK(rv, 32'h00000014)
        rd(4'hE);
        `CHK(rv, 32'h00000000)
        $display("reset test done");
        for (i = 3; i <= 6; i++) begin
            wr(i[3:0], 32'h0000FFFF);
            rd(i[3:0]);
            `CHK(rv, 32'h0000270F)
        end
        $display("range test done");
        wr(`AVC_REG_SRC1, 32'h00000000);
        wr(`AVC_REG_SRC2, 32'h00000030);
        wr(`AVC_REG_SET2, 32'h00000064);
        wr(`AVC_REG_HYST, 32'h00000019);
        wr(`AVC_REG_OFFSET, 32'h00000000);
        for (m = 0; m < 5; m++) begin
            wr(`AVC_REG_CTRL, 32'h00000000);
            wr(`AVC_REG_CTRL, 32'h00000020 | 32'(m));
            #1 `CHK(contact_o, 1'b0)
            exp_c = 1'b0;
            for (i = 0; i < 10; i++) begin
                scan(seq[i]);
                exp_c = next_c(m, seq[i], 100, 25, exp_c);
                `CHK(contact_o, exp_c)
            end
        end
        wr(`AVC_REG_CTRL, 32'h00000024);
        scan(10'h06E);
        rd(`AVC_REG_STATUS);
        `CHK(rv, 32'h00000005)
        wr(`AVC_REG_CTRL, 32'h00000025);
        scan(10'h04A);
        rd(`AVC_REG_STATUS);
        `CHK(rv, 32'h00000001)
        $display("mode test done");
        @(posedge ref_clk_i);
        counter_value_i[5*16 +: 16] <= 16'h27F9;
        timer_value_i[3*16 +: 16]   <= 16'h270F;
        analog_pin_i[29:20]         <= 10'h3FF;
        wr(`AVC_REG_SRC1, 32'h00000025);
        wr(`AVC_REG_SRC2, 32'h00000013);
        wr(`AVC_REG_OFFSET, 32'h00000007);
        wr(`AVC_REG_CTRL, 32'h00000030);
        scan(10'h000);
        rd(`AVC_REG_VAL1);
        `CHK(rv, 32'h00002800)
        rd(`AVC_REG_VAL2);
        `CHK(rv, 32'h05F592E1)
        rd(`AVC_REG_SHOW1);
        `CHK(rv, 32'h000000E9)
        rd(`AVC_REG_SHOW2);
        `CHK(rv, 32'h0000270F)
        wr(`AVC_REG_SRC1, 32'h00000002);
        wr(`AVC_REG_GAIN1, 32'h00000002);
        wr(`AVC_REG_CTRL, 32'h00000028);
        scan(10'h000);
        rd(`AVC_REG_VAL1);
        `CHK(rv, 32'h00000805)
        $display("operand test done");
        end_of_test();
    end
endmodule : tb_avc_top

// File: logic/avc_operand.sv
// operand path: source pick, gain, offset and display folding
// assumes all inputs are already in the ref_clk_i domain
`timescale 1ns/100ps
`include "avc_map.svh"
module avc_operand (
    // selection and settings
    input  wire logic [`AVC_SRC_W-1:0]            src_sel_i,
    input  wire logic [`AVC_PARAM_W-1:0]          setpoint_i,
    input  wire logic [`AVC_PARAM_W-1:0]          gain_i,
    input  wire logic [`AVC_PARAM_W-1:0]          offset_i,
    input  wire logic                             gain_used_i,
    // sources
    input  wire logic [`AVC_ANA_N*`AVC_ANA_W-1:0] analog_i,
    input  wire logic [`AVC_TC_N*`AVC_TC_W-1:0]   timer_i,
    input  wire logic [`AVC_TC_N*`AVC_TC_W-1:0]   counter_i,
    // results
    output avc_pkg::avc_value_type                value_o,
    output logic [`AVC_TC_W-1:0]                  show_o
);
    import avc_pkg::*;

    avc_src_type                kind;
    wire logic [`AVC_IDX_W-1:0] idx;
    wire logic [`AVC_ANA_W-1:0] ana_pick;
    wire logic [`AVC_TC_W-1:0]  tim_pick;
    wire logic [`AVC_TC_W-1:0]  cnt_pick;
    wire logic [`AVC_TC_W-1:0]  raw;
    wire logic [`AVC_VAL_W-1:0] raw_ext;
    wire logic [`AVC_VAL_W-1:0] gain_ext;
    wire logic [`AVC_VAL_W-1:0] offs_ext;
    wire logic [`AVC_VAL_W-1:0] product;
    wire logic [`AVC_VAL_W-1:0] scaled;

    assign kind = avc_src_type'(src_sel_i[`AVC_SRC_W-1:`AVC_IDX_W]);
    assign idx  = src_sel_i[`AVC_IDX_W-1:0];
    assign ana_pick = analog_i[idx[`AVC_ANA_IDX_W-1:0]*`AVC_ANA_W +: `AVC_ANA_W];
    assign tim_pick = timer_i[idx*`AVC_TC_W +: `AVC_TC_W];
    assign cnt_pick = counter_i[idx*`AVC_TC_W +: `AVC_TC_W];

    assign raw = (kind == src_analog)  ? {{(`AVC_TC_W-`AVC_ANA_W){1'b0}}, ana_pick} :
                 (kind == src_timer)   ? tim_pick :
                 (kind == src_counter) ? cnt_pick :
                 {{(`AVC_TC_W-`AVC_PARAM_W){1'b0}}, setpoint_i};

    // widths leave headroom: 65535 * 9999 + 9999 stays below 2**31
    assign raw_ext  = {{(`AVC_VAL_W-`AVC_TC_W){1'b0}}, raw};
    assign gain_ext = {{(`AVC_VAL_W-`AVC_PARAM_W){1'b0}}, gain_i};
    assign offs_ext = {{(`AVC_VAL_W-`AVC_PARAM_W){1'b0}}, offset_i};
    assign product  = raw_ext * gain_ext;
    assign scaled   = gain_used_i ? product : raw_ext;
    assign value_o  = avc_value_type'(scaled + offs_ext);

    assign show_o = (kind == src_counter && raw > `AVC_FOLD_LIMIT) ?
                    raw - `AVC_FOLD_STEP : raw;
endmodule : avc_operand

// File: logic/avc_top.sv
// analog value comparator: registers, scan evaluation and contact
// assumes analog codes arrive from pins, timer and counter values
// and the scan strobe come from logic on ref_clk_i
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "avc_map.svh"
module avc_top (
    // clock and reset
    input  wire logic                             ref_clk_i,
    input  wire logic                             rst_b_i,

    // register port
    input  wire logic [`AVC_ADDR_W-1:0]           reg_addr_i,
    input  wire logic [`AVC_DATA_W-1:0]           reg_wdata_i,
    input  wire logic                             reg_wr_i,
    input  wire logic                             reg_rd_i,
    output logic [`AVC_DATA_W-1:0]                reg_rdata_o,

    // operand sources
    input  wire logic [`AVC_ANA_N*`AVC_ANA_W-1:0] analog_pin_i,
    input  wire logic [`AVC_TC_N*`AVC_TC_W-1:0]   timer_value_i,
    input  wire logic [`AVC_TC_N*`AVC_TC_W-1:0]   counter_value_i,

    // program scan
    input  wire logic                             scan_i,
    output logic                                  scan_done_o,

    // contact
    output logic                                  contact_o
);
    import avc_pkg::*;

    // settings limited to 0..9999
    function automatic logic [`AVC_PARAM_W-1:0] clamp_param(
        input logic [`AVC_DATA_W-1:0] d
    );
        if (d > {{(`AVC_DATA_W-`AVC_PARAM_W){1'b0}}, `AVC_PARAM_MAX}) begin
            clamp_param = `AVC_PARAM_MAX;
        end else begin
            clamp_param = d[`AVC_PARAM_W-1:0];
        end
    endfunction : clamp_param

    // one register index against the bus address
    function automatic logic reg_hit(
        input logic [`AVC_ADDR_W-1:0] a,
        input logic [`AVC_ADDR_W-1:0] idx
    );
        reg_hit = (a == idx);
    endfunction : reg_hit

    // analog synchroniser
    logic [`AVC_ANA_N*`AVC_ANA_W-1:0] ana_meta;
    logic [`AVC_ANA_N*`AVC_ANA_W-1:0] ana_sync;

    // settings
    logic [`AVC_CTRL_W-1:0]           ctrl;
    logic [`AVC_SRC_W-1:0]            first_src;
    logic [`AVC_SRC_W-1:0]            second_src;
    logic [`AVC_PARAM_W-1:0]          first_gain;
    logic [`AVC_PARAM_W-1:0]          second_gain;
    logic [`AVC_PARAM_W-1:0]          first_offset;
    logic [`AVC_PARAM_W-1:0]          switch_hysteresis;
    logic [`AVC_PARAM_W-1:0]          first_setpoint;
    logic [`AVC_PARAM_W-1:0]          second_setpoint;

    // scan stage
    avc_value_type                    first_operand;
    avc_value_type                    second_operand;
    avc_value_type                    upper_bound;
    avc_value_type                    lower_bound;
    logic                             eval_pend;
    logic [`AVC_TC_W-1:0]             first_show;
    logic [`AVC_TC_W-1:0]             second_show;

    // combinational results
    avc_value_type                    first_value;
    avc_value_type                    second_value;
    wire logic [`AVC_TC_W-1:0]        first_show_now;
    wire logic [`AVC_TC_W-1:0]        second_show_now;
    avc_value_type                    hyst_ext;
    avc_value_type                    next_upper;
    avc_value_type                    next_lower;
    avc_mode_type                     mode;
    wire logic                        mode_legal;
    wire logic                        enabled;
    wire logic                        a_below_b;
    wire logic                        a_same_b;
    wire logic                        a_above_b;
    wire logic                        a_above_upper;
    wire logic                        a_below_lower;
    logic                             turn_on;
    logic                             turn_off;
    wire logic                        next_contact;
    wire logic [`AVC_DATA_W-1:0]      rd_mux;
    wire logic [`AVC_DATA_W-1:0]      status_word;

    // register write strobes
    wire logic                        wr_ctrl;
    wire logic                        wr_src1;
    wire logic                        wr_src2;
    wire logic                        wr_gain1;
    wire logic                        wr_gain2;
    wire logic                        wr_offs;
    wire logic                        wr_hyst;
    wire logic                        wr_set1;
    wire logic                        wr_set2;

    // analog pins pass two flops before any use
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ana_meta <= '0;
            ana_sync <= '0;
        end else begin
            ana_meta <= analog_pin_i;
            ana_sync <= ana_meta;
        end
    end

    // operand paths
    avc_operand u_first (
        .src_sel_i   (first_src),
        .setpoint_i  (first_setpoint),
        .gain_i      (first_gain),
        .offset_i    (first_offset),
        .gain_used_i (ctrl[`AVC_CTRL_GAIN1]),
        .analog_i    (ana_sync),
        .timer_i     (timer_value_i),
        .counter_i   (counter_value_i),
        .value_o     (first_value),
        .show_o      (first_show_now)
    );

    // second operand carries no offset
    avc_operand u_second (
        .src_sel_i   (second_src),
        .setpoint_i  (second_setpoint),
        .gain_i      (second_gain),
        .offset_i    (`AVC_PARAM_RESET),
        .gain_used_i (ctrl[`AVC_CTRL_GAIN2]),
        .analog_i    (ana_sync),
        .timer_i     (timer_value_i),
        .counter_i   (counter_value_i),
        .value_o     (second_value),
        .show_o      (second_show_now)
    );

    // hysteresis band around the second operand
    assign hyst_ext   = avc_value_type'({{(`AVC_VAL_W-`AVC_PARAM_W){1'b0}}, switch_hysteresis});
    assign next_upper = second_value + hyst_ext;
    assign next_lower = second_value - hyst_ext;

    // mode decode
    assign mode       = avc_mode_type'(ctrl[`AVC_CTRL_MODE_W-1:0]);
    assign mode_legal = ctrl[`AVC_CTRL_MODE_W-1:0] <= `AVC_MODE_LAST;
    assign enabled    = ctrl[`AVC_CTRL_EN];

    // signed comparisons on the latched operands
    assign a_below_b     = first_operand < second_operand;
    assign a_same_b      = first_operand == second_operand;
    assign a_above_b     = first_operand > second_operand;
    assign a_above_upper = first_operand > upper_bound;
    assign a_below_lower = first_operand < lower_bound;

    always_comb begin
        turn_on  = 1'b0;
        turn_off = 1'b0;
        unique case (mode)
            mode_below: begin
                turn_on  = a_below_b;
                turn_off = a_above_upper;
            end
            mode_below_or_same: begin
                turn_on  = a_below_b | a_same_b;
                turn_off = a_above_upper;
            end
            mode_same: begin
                turn_on  = a_same_b;
                turn_off = a_below_lower | a_above_upper;
            end
            mode_above_or_same: begin
                turn_on  = a_above_b | a_same_b;
                turn_off = a_below_lower;
            end
            mode_above: begin
                turn_on  = a_above_b;
                turn_off = a_below_lower;
            end
            default: begin
                turn_on  = 1'b0;
                turn_off = 1'b0;
            end
        endcase
    end

    // inside the band the contact keeps its state
    assign next_contact = !enabled ? 1'b0 :
                          !eval_pend ? contact_o :
                          turn_on ? 1'b1 :
                          turn_off ? 1'b0 :
                          contact_o;

    // scan stage: operands taken once per scan strobe
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_operand  <= '0;
            second_operand <= '0;
            upper_bound    <= '0;
            lower_bound    <= '0;
            first_show     <= '0;
            second_show    <= '0;
        end else if (scan_i) begin
            first_operand  <= first_value;
            second_operand <= second_value;
            upper_bound    <= next_upper;
            lower_bound    <= next_lower;
            first_show     <= first_show_now;
            second_show    <= second_show_now;
        end
    end

    // scan answer and contact
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eval_pend   <= 1'b0;
            scan_done_o <= 1'b0;
            contact_o   <= 1'b0;
        end else begin
            eval_pend   <= scan_i;
            scan_done_o <= eval_pend;
            contact_o   <= next_contact;
        end
    end

    // write decode, one strobe per register
    assign wr_ctrl  = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_CTRL);
    assign wr_src1  = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_SRC1);
    assign wr_src2  = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_SRC2);
    assign wr_gain1 = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_GAIN1);
    assign wr_gain2 = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_GAIN2);
    assign wr_offs  = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_OFFSET);
    assign wr_hyst  = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_HYST);
    assign wr_set1  = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_SET1);
    assign wr_set2  = reg_wr_i && reg_hit(reg_addr_i, `AVC_REG_SET2);

    // register writes
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= `AVC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata_i[`AVC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_src  <= `AVC_SRC_RESET;
            second_src <= `AVC_SRC_RESET;
        end else begin
            if (wr_src1) begin
                first_src <= reg_wdata_i[`AVC_SRC_W-1:0];
            end
            if (wr_src2) begin
                second_src <= reg_wdata_i[`AVC_SRC_W-1:0];
            end
        end
    end

    // parameters clamped to 0..9999 on write
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_gain        <= `AVC_PARAM_RESET;
            second_gain       <= `AVC_PARAM_RESET;
            first_offset      <= `AVC_PARAM_RESET;
            switch_hysteresis <= `AVC_HYST_RESET;
        end else begin
            if (wr_gain1) begin
                first_gain <= clamp_param(reg_wdata_i);
            end
            if (wr_gain2) begin
                second_gain <= clamp_param(reg_wdata_i);
            end
            if (wr_offs) begin
                first_offset <= clamp_param(reg_wdata_i);
            end
            if (wr_hyst) begin
                switch_hysteresis <= clamp_param(reg_wdata_i);
            end
        end
    end

    // setpoints for the setpoint source kind
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_setpoint  <= `AVC_PARAM_RESET;
            second_setpoint <= `AVC_PARAM_RESET;
        end else begin
            if (wr_set1) begin
                first_setpoint <= clamp_param(reg_wdata_i);
            end
            if (wr_set2) begin
                second_setpoint <= clamp_param(reg_wdata_i);
            end
        end
    end

    // read selection
    assign status_word = {{(`AVC_DATA_W-3){1'b0}}, mode_legal, eval_pend, contact_o};

    assign rd_mux =
        (reg_addr_i == `AVC_REG_CTRL)   ? {{(`AVC_DATA_W-`AVC_CTRL_W){1'b0}}, ctrl} :
        (reg_addr_i == `AVC_REG_SRC1)   ? {{(`AVC_DATA_W-`AVC_SRC_W){1'b0}}, first_src} :
        (reg_addr_i == `AVC_REG_SRC2)   ? {{(`AVC_DATA_W-`AVC_SRC_W){1'b0}}, second_src} :
        (reg_addr_i == `AVC_REG_GAIN1)  ? {{(`AVC_DATA_W-`AVC_PARAM_W){1'b0}}, first_gain} :
        (reg_addr_i == `AVC_REG_GAIN2)  ? {{(`AVC_DATA_W-`AVC_PARAM_W){1'b0}}, second_gain} :
        (reg_addr_i == `AVC_REG_OFFSET) ? {{(`AVC_DATA_W-`AVC_PARAM_W){1'b0}}, first_offset} :
        (reg_addr_i == `AVC_REG_HYST)   ?
            {{(`AVC_DATA_W-`AVC_PARAM_W){1'b0}}, switch_hysteresis} :
        (reg_addr_i == `AVC_REG_SET1)   ?
            {{(`AVC_DATA_W-`AVC_PARAM_W){1'b0}}, first_setpoint} :
        (reg_addr_i == `AVC_REG_SET2)   ?
            {{(`AVC_DATA_W-`AVC_PARAM_W){1'b0}}, second_setpoint} :
        (reg_addr_i == `AVC_REG_STATUS) ? status_word :
        (reg_addr_i == `AVC_REG_VAL1)   ? first_operand :
        (reg_addr_i == `AVC_REG_VAL2)   ? second_operand :
        (reg_addr_i == `AVC_REG_SHOW1)  ?
            {{(`AVC_DATA_W-`AVC_TC_W){1'b0}}, first_show} :
        (reg_addr_i == `AVC_REG_SHOW2)  ?
            {{(`AVC_DATA_W-`AVC_TC_W){1'b0}}, second_show} :
        {`AVC_DATA_W{1'b0}};

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule : avc_top

// File: pkg/avc_map.svh
// constants of the analog value comparator: offsets, fields, resets, limits
// assumes a single clock and the plain register port of the top module
`ifndef AVC_MAP_SVH
`define AVC_MAP_SVH

`define AVC_ADDR_W       4
`define AVC_DATA_W       32
`define AVC_VAL_W        32
`define AVC_ANA_W        10
`define AVC_ANA_N        4
`define AVC_ANA_IDX_W    2
`define AVC_TC_W         16
`define AVC_TC_N         16
`define AVC_IDX_W        4
`define AVC_SRC_W        6
`define AVC_PARAM_W      14
`define AVC_PARAM_MAX    14'h270F
`define AVC_FOLD_LIMIT   16'h270F
`define AVC_FOLD_STEP    16'h2710

`define AVC_REG_CTRL     4'h0
`define AVC_REG_SRC1     4'h1
`define AVC_REG_SRC2     4'h2
`define AVC_REG_GAIN1    4'h3
`define AVC_REG_GAIN2    4'h4
`define AVC_REG_OFFSET   4'h5
`define AVC_REG_HYST     4'h6
`define AVC_REG_SET1     4'h7
`define AVC_REG_SET2     4'h8
`define AVC_REG_STATUS   4'h9
`define AVC_REG_VAL1     4'hA
`define AVC_REG_VAL2     4'hB
`define AVC_REG_SHOW1    4'hC
`define AVC_REG_SHOW2    4'hD

`define AVC_CTRL_W       6
`define AVC_CTRL_MODE_W  3
`define AVC_CTRL_GAIN1   3
`define AVC_CTRL_GAIN2   4
`define AVC_CTRL_EN      5
`define AVC_MODE_LAST    3'h4

`define AVC_CTRL_RESET   6'h00
`define AVC_SRC_RESET    6'h00
`define AVC_PARAM_RESET  14'h0000
`define AVC_HYST_RESET   14'h0014

`endif

// File: pkg/avc_pkg.sv
// types of the analog value comparator
// assumes avc_map.svh on the include path
`include "avc_map.svh"
package avc_pkg;
    typedef enum logic [`AVC_CTRL_MODE_W-1:0] {
        mode_below,
        mode_below_or_same,
        mode_same,
        mode_above_or_same,
        mode_above
    } avc_mode_type;
    typedef enum logic [1:0] {
        src_analog,
        src_timer,
        src_counter,
        src_setpoint
    } avc_src_type;
    typedef logic signed [`AVC_VAL_W-1:0] avc_value_type;
endpackage : avc_pkg
